// >>> phy_mgmt_config_regs_tb.sv
// Bench: host controller and register bank joined by the link.
// Software port driven here; read data compared through a queue, port outputs directly.
`timescale 1ns/100ps
module phy_mgmt_config_regs_tb;
    import pmc_pkg::*;
    logic        clk_sys = 1'b0, rst_b = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, patch_done = 1'b0, rd_d = 1'b0;
    logic [3:0]  sw_addr = 4'h0;
    logic [15:0] sw_wdata = 16'h0000, c45_rdata = 16'h0000, rv = 16'h0000, sw_rdata, c45_ctrl;
    logic        patch_req, ports_active, mac_rgmii, loopback_en, full_duplex, mac_isolate, coll_test_en, dly_en;
    logic [2:0]  rx_dly, tx_dly;
    pmc_speed_e  speed_sel;
    logic [15:0] q_exp[$];
    logic        q_chk[$];
    logic [31:0] seed = 32'h0cc9;
    int          num_errors = 0, cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) patch_done <= patch_req;
    pmc_mgmt_if u_link (.clk_sys(clk_sys));
    pmc_host_ctrl #(.RST_WAIT(50)) u_pmc_host_ctrl (.clk_sys(clk_sys), .rst_b(rst_b), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .power_good(1'b1),
        .refclk_ok(1'b1), .patch_done(patch_done), .patch_req(patch_req), .mgmt(u_link));
    pmc_dev_regs u_pmc_dev_regs (.clk_sys(clk_sys), .rst_b(rst_b), .mgmt(u_link), .ports_active(ports_active),
        .mac_rgmii(mac_rgmii), .loopback_en(loopback_en), .speed_sel(speed_sel), .full_duplex(full_duplex),
        .mac_isolate(mac_isolate), .an_restart(), .coll_test_en(coll_test_en), .master_role(),
        .rx_clk_delay(rx_dly), .tx_clk_delay(tx_dly), .rgmii_delay_en(dly_en), .c45_ctrl(c45_ctrl),
        .c45_data_wr(), .c45_wdata(), .c45_rdata(c45_rdata));
    pmc_link_props #(.RST_WAIT(50)) u_pmc_link_props (.clk_sys(clk_sys), .rst_b(rst_b),
        .hw_reset_b(u_link.hw_reset_b), .hold_inactive_pin(u_link.hold_inactive_pin), .addr(u_link.addr),
        .wdata(u_link.wdata), .wr(u_link.wr), .rd(u_link.rd), .rdata(u_link.rdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    task automatic sw_acc(input logic [3:0] a, input logic [15:0] d, input logic w, input logic c,
                          input logic [15:0] exp);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= w;
        sw_rd <= !w;
        if (!w) begin
            q_exp.push_back(exp);
            q_chk.push_back(c);
        end
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
    endtask : sw_acc
    task automatic dev_acc(input logic [4:0] a, input logic [15:0] d, input logic w, input logic [15:0] exp);
        sw_acc(HR_CONTROL, {6'h00, w, 3'h0, a, 1'b0}, 1'b1, 1'b0, 16'h0000);
        sw_acc(HR_ACC, d, 1'b1, 1'b0, 16'h0000);
        repeat (8) @(posedge clk_sys);
        if (!w)
            sw_acc(HR_RDATA, 16'h0000, 1'b0, 1'b1, exp);
        #1;
    endtask : dev_acc
    always @(posedge clk_sys) begin
        if (rd_d && q_chk.size() > 0) begin
            if (q_chk.pop_front())
                check("sw_rdata", sw_rdata, q_exp[0]);
            void'(q_exp.pop_front());
        end
        rd_d <= sw_rd;
    end
    initial begin
        #2_000_000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        sw_acc(HR_CONFIG, 16'h0007, 1'b1, 1'b0, 16'h0000);
        check("ports_active", ports_active, 1'b0);
        sw_acc(HR_CONTROL, 16'h0001, 1'b1, 1'b0, 16'h0000);
        for (int i = 0; i < 400 && !rv[1]; i++) begin
            sw_acc(HR_STATUS, 16'h0000, 1'b0, 1'b0, 16'h0000);
            #1 rv = sw_rdata;
        end
        check("done", rv[1], 1'b1);
        repeat (3) @(posedge clk_sys);
        check("ports_active", ports_active, 1'b1);
        check("dly_en", dly_en, 1'b0);
        dev_acc(REG_PAGE_SELECT, PAGE_EXT2, 1'b1, 16'h0000);
        dev_acc(REG_EXT_PHY_CTL1, 16'h0000, 1'b0, 16'h0000);
        dev_acc(REG_RGMII_DELAY, 16'h0035, 1'b1, 16'h0000);
        check("rx_dly", rx_dly, 3'h3);
        check("tx_dly", tx_dly, 3'h5);
        dev_acc(REG_RGMII_DELAY, 16'h0000, 1'b0, 16'h0035);
        dev_acc(REG_PAGE_SELECT, PAGE_MAIN, 1'b1, 16'h0000);
        dev_acc(REG_RGMII_DELAY, 16'h0000, 1'b0, 16'h0000);
        dev_acc(REG_EXT_PHY_CTL1, 16'h1000, 1'b1, 16'h0000);
        check("mac_rgmii", mac_rgmii, 1'b1);
        dev_acc(REG_EXT_PHY_CTL1, 16'h0000, 1'b0, 16'h1000);
        dev_acc(REG_MASTER_SLAVE, 16'h0800, 1'b1, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            rv = (seed[15:0] & 16'h5dbf) | {2'b00, k[0], 6'h00, k[1], 6'h00};
            dev_acc(REG_MODE_CONTROL, rv, 1'b1, 16'h0000);
            check("speed_sel", speed_sel, k[1:0]);
            check("loopback_en", loopback_en, rv[14]);
            check("full_duplex", full_duplex, rv[8]);
            check("mac_isolate", mac_isolate, rv[10]);
            check("coll_test_en", coll_test_en, rv[7]);
            dev_acc(REG_MODE_CONTROL, 16'h0000, 1'b0, rv & MC_WMASK);
        end
        dev_acc(REG_MODE_CONTROL, 16'h1240, 1'b1, 16'h0000);
        dev_acc(REG_MODE_CONTROL, 16'h0000, 1'b0, 16'h1040);
        seed = xs(seed);
        @(posedge clk_sys) c45_rdata <= seed[31:16];
        dev_acc(REG_C45_CTRL, seed[15:0], 1'b1, 16'h0000);
        check("c45_ctrl", c45_ctrl, seed[15:0]);
        dev_acc(REG_C45_DATA, 16'h0000, 1'b0, seed[31:16]);
        dev_acc(5'h0b, 16'h0000, 1'b0, 16'h0000);
        dev_acc(REG_MODE_CONTROL, 16'h8000, 1'b1, 16'h0000);
        dev_acc(REG_MODE_CONTROL, 16'h0000, 1'b0, MC_RESET);
        check("c45_ctrl", c45_ctrl, C45_RESET);
        repeat (4) @(posedge clk_sys);
        wrap_up();
    end
endmodule : phy_mgmt_config_regs_tb

// >>> pmc_dev_regs.sv
// Device end: management register bank with paging and mode control.
// Assumes the host keeps the power-up and access timing of the sequence.
`timescale 1ns/100ps
module pmc_dev_regs
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   rst_b,
    // Management link
    pmc_mgmt_if.device  mgmt,
    // Port control outputs and clause 45 read data input
    output logic        ports_active,
    output logic        mac_rgmii,
    output logic        loopback_en,
    output pmc_speed_e  speed_sel,
    output logic        full_duplex,
    output logic        mac_isolate,
    output logic        an_restart,
    output logic        coll_test_en,
    output logic        master_role,
    output logic [2:0]  rx_clk_delay,
    output logic [2:0]  tx_clk_delay,
    output logic        rgmii_delay_en,
    output logic [15:0] c45_ctrl,
    output logic        c45_data_wr,
    output logic [15:0] c45_wdata,
    input  wire logic [15:0] c45_rdata
);
    logic [15:0] mode_control;
    logic [15:0] extended_phy_control_one;
    logic [15:0] page_select;
    logic [15:0] rgmii_delay_control;
    logic [15:0] master_slave;
    logic [15:0] c45_ctrl_q;
    logic [1:0]  hold_sync;
    logic [1:0]  hwrst_sync;
    logic [15:0] rdata_q;
    logic        swrst_busy;
    logic        an_busy;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            hold_sync  <= 2'h3;
            hwrst_sync <= 2'h0;
        end else begin
            hold_sync  <= {hold_sync[0], mgmt.hold_inactive_pin};
            hwrst_sync <= {hwrst_sync[0], mgmt.hw_reset_b};
        end
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire page_main = (page_select == PAGE_MAIN);
    wire page_ext2 = (page_select == PAGE_EXT2);
    wire sel_mc    = (mgmt.addr == REG_MODE_CONTROL);
    wire sel_ms    = (mgmt.addr == REG_MASTER_SLAVE);
    wire sel_c45c  = (mgmt.addr == REG_C45_CTRL);
    wire sel_c45d  = (mgmt.addr == REG_C45_DATA);
    wire sel_ps    = (mgmt.addr == REG_PAGE_SELECT);
    wire sel_epc   = (mgmt.addr == REG_EXT_PHY_CTL1) && page_main;
    wire sel_rd    = (mgmt.addr == REG_RGMII_DELAY) && page_ext2;
    wire wr_en     = mgmt.wr && !swrst_busy;
    wire soft_rst  = wr_en && sel_mc && mgmt.wdata[MC_SW_RESET];
    wire an_start  = wr_en && sel_mc && mgmt.wdata[MC_RESTART_AN];
    wire regs_clr  = !rst_b || !hwrst_sync[1];
    wire [15:0] next_mode_control = (mgmt.wdata & MC_WMASK) | (mode_control & ~MC_WMASK);

    pmc_pulse_timer #(.CYCLES(SWRST_BUSY_CYC)) u_swrst (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .start   (soft_rst),
        .busy    (swrst_busy)
    );

    pmc_pulse_timer #(.CYCLES(AN_BUSY_CYC)) u_an (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .start   (an_start),
        .busy    (an_busy)
    );

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (regs_clr || soft_rst) begin
            mode_control             <= MC_RESET;
            extended_phy_control_one <= EPC_RESET;
            page_select              <= PAGE_MAIN;
            rgmii_delay_control      <= RD_RESET;
            master_slave             <= MS_RESET;
            c45_ctrl_q               <= C45_RESET;
        end else if (wr_en) begin
            if (sel_mc) begin
                mode_control <= next_mode_control & ~(16'h0001 << MC_RESTART_AN);
            end
            if (sel_epc) begin
                extended_phy_control_one <= mgmt.wdata & EPC_WMASK;
            end
            if (sel_ps) begin
                page_select <= mgmt.wdata;
            end
            if (sel_rd) begin
                rgmii_delay_control <= mgmt.wdata;
            end
            if (sel_ms) begin
                master_slave <= mgmt.wdata;
            end
            if (sel_c45c) begin
                c45_ctrl_q <= mgmt.wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    wire [15:0] mc_view = mode_control
                        | ({15'h0000, swrst_busy} << MC_SW_RESET)
                        | ({15'h0000, an_busy} << MC_RESTART_AN);
    wire [15:0] rd_mux  = sel_mc   ? mc_view :
                          sel_ms   ? master_slave :
                          sel_c45c ? c45_ctrl_q :
                          sel_c45d ? c45_rdata :
                          sel_ps   ? page_select :
                          sel_epc  ? extended_phy_control_one :
                          sel_rd   ? rgmii_delay_control :
                          16'h0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_q <= 16'h0000;
        end else if (mgmt.rd) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ports_active <= 1'b0;
            c45_data_wr  <= 1'b0;
            c45_wdata    <= 16'h0000;
            an_restart   <= 1'b0;
        end else begin
            ports_active <= !hold_sync[1] && hwrst_sync[1];
            c45_data_wr  <= wr_en && sel_c45d;
            c45_wdata    <= wr_en && sel_c45d ? mgmt.wdata : c45_wdata;
            an_restart   <= an_start;
        end
    end

    // ----------------------------------------------------------------
    // Link read data and mode outputs
    // ----------------------------------------------------------------
    assign mgmt.rdata     = rdata_q;
    assign mac_rgmii      = extended_phy_control_one[EPC_MAC_RGMII];
    assign speed_sel      = pmc_speed_e'({mode_control[MC_SPEED_MSB], mode_control[MC_SPEED_LSB]});
    assign full_duplex    = mode_control[MC_DUPLEX];
    assign loopback_en    = mode_control[MC_LOOPBACK];
    assign mac_isolate    = mode_control[MC_ISOLATE];
    assign coll_test_en   = mode_control[MC_COLL_TEST];
    assign master_role    = master_slave[11];
    assign rgmii_delay_en = rgmii_delay_control[RD_ENABLE_BIT];
    assign rx_clk_delay   = rgmii_delay_control[6:4];
    assign tx_clk_delay   = rgmii_delay_control[2:0];
    assign c45_ctrl       = c45_ctrl_q;
endmodule : pmc_dev_regs

// >>> pmc_host_ctrl.sv
// Host end: runs the power-up configuration sequence over the link.
// Software reaches control/status through a small register port.
`timescale 1ns/100ps

// Functional notes
// - Release reset only with power and clock
// - Wait 120 ms after reset release
// - Load vendor patch before configuring
// - Register 23 bit 12 selects RGMII
// - Main registers need page zero
// - Extended page 2 needs page two
// - RGMII: clear RGMII_DELAY_CONTROL.11, set delays
// - Software reset restores defaults, self-clears
// - Wait 1 us after software reset
// - Poll register 0 until reset clears
// - Hold pin high keeps ports inactive
// - Loopback uses current speed and duplex
// - Speed bits 6:13 encode 10/100/1000
// - Isolate disables MAC-side interface
// - Restart auto-negotiation, self-clearing
// - Bit 7 enables collision test
// - Set master role before forced 1000
// - Power down on link drop forced 1000
// - Read-modify-write registers with reserved bits
// - Reserved bits ignore writes
// - Clause 45 space via registers 13/14
module pmc_host_ctrl
    import pmc_pkg::*;
#(
    parameter int RST_WAIT = RST_WAIT_CYC
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Software port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic [15:0]      sw_rdata,
    // Board status
    input  wire logic        power_good,
    input  wire logic        refclk_ok,
    input  wire logic        patch_done,
    output logic             patch_req,
    // Management link
    pmc_mgmt_if.host         mgmt
);
    typedef enum {S_IDLE, S_WAIT_PWR, S_RST_WAIT, S_PATCH, S_PG0, S_RD23, S_WR23, S_RD0, S_WR0,
                  S_SW_WAIT, S_POLL, S_POLL_CHK, S_PG2, S_RD20, S_WR20, S_PG0B, S_RELEASE,
                  S_DONE, S_ACC, S_ACC_RD} pmc_state_e;

    pmc_state_e  state;
    logic [23:0] wait_cnt;
    logic [15:0] cfg;
    logic [15:0] rd_val;
    logic [15:0] acc;
    logic        hold_pin;
    logic        hw_rst_b;
    logic [4:0]  addr_q;
    logic [15:0] wdata_q;
    logic        wr_q;
    logic        rd_q;
    logic        rd_pend;
    logic [15:0] sw_rdata_q;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire sw_start  = sw_wr && (sw_addr == HR_CONTROL) && sw_wdata[0];
    wire sw_acc    = sw_wr && (sw_addr == HR_ACC) && (state == S_DONE);
    wire use_rgmii = cfg[0];
    wire use_patch = cfg[1];
    wire use_hold  = cfg[2];
    wire wait_done = (wait_cnt == 24'h000000);
    wire [15:0] link_rd = mgmt.rdata;
    wire [15:0] ext_new = (link_rd & ~(16'h0001 << EPC_MAC_RGMII))
                        | ({15'h0000, use_rgmii} << EPC_MAC_RGMII);
    wire [15:0] mc_new  = link_rd | (16'h0001 << MC_SW_RESET);
    wire [15:0] rd_new  = (link_rd & 16'hf788) | {9'h000, RD_DELAY_DEF, 1'b0, RD_DELAY_DEF};

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state    <= S_IDLE;
            wait_cnt <= 24'h000000;
            hold_pin <= 1'b1;
            hw_rst_b <= 1'b0;
            addr_q   <= 5'h00;
            wdata_q  <= 16'h0000;
            wr_q     <= 1'b0;
            rd_q     <= 1'b0;
            rd_val   <= 16'h0000;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (wait_cnt != 24'h000000) begin
                wait_cnt <= wait_cnt - 24'h000001;
            end
            case (state)
                S_IDLE: begin
                    if (sw_start) begin
                        hold_pin <= use_hold;
                        hw_rst_b <= 1'b0;
                        state    <= S_WAIT_PWR;
                    end
                end
                S_WAIT_PWR: begin
                    if (power_good && refclk_ok) begin
                        hw_rst_b <= 1'b1;
                        wait_cnt <= 24'(RST_WAIT);
                        state    <= S_RST_WAIT;
                    end
                end
                S_RST_WAIT: if (wait_done) state <= use_patch ? S_PATCH : S_PG0;
                S_PATCH: if (patch_done) state <= S_PG0;
                S_PG0: begin
                    addr_q  <= REG_PAGE_SELECT;
                    wdata_q <= PAGE_MAIN;
                    wr_q    <= 1'b1;
                    state   <= S_RD23;
                end
                S_RD23: begin
                    addr_q <= REG_EXT_PHY_CTL1;
                    rd_q   <= 1'b1;
                    state  <= S_WR23;
                end
                S_WR23: if (!rd_q) begin
                    wdata_q <= ext_new;
                    wr_q    <= 1'b1;
                    state   <= S_RD0;
                end
                S_RD0: begin
                    addr_q <= REG_MODE_CONTROL;
                    rd_q   <= 1'b1;
                    state  <= S_WR0;
                end
                S_WR0: if (!rd_q) begin
                    wdata_q  <= mc_new;
                    wr_q     <= 1'b1;
                    wait_cnt <= 24'(SWRST_WAIT_CYC);
                    state    <= S_SW_WAIT;
                end
                S_SW_WAIT: if (wait_done && !wr_q) state <= S_POLL;
                S_POLL: begin
                    rd_q  <= 1'b1;
                    state <= S_POLL_CHK;
                end
                S_POLL_CHK: if (!rd_q) begin
                    if (link_rd[MC_SW_RESET]) state <= S_POLL;
                    else state <= use_rgmii ? S_PG2 : S_RELEASE;
                end
                S_PG2: begin
                    addr_q  <= REG_PAGE_SELECT;
                    wdata_q <= PAGE_EXT2;
                    wr_q    <= 1'b1;
                    state   <= S_RD20;
                end
                S_RD20: begin
                    addr_q <= REG_RGMII_DELAY;
                    rd_q   <= 1'b1;
                    state  <= S_WR20;
                end
                S_WR20: if (!rd_q) begin
                    wdata_q <= rd_new;
                    wr_q    <= 1'b1;
                    state   <= S_PG0B;
                end
                S_PG0B: begin
                    addr_q  <= REG_PAGE_SELECT;
                    wdata_q <= PAGE_MAIN;
                    wr_q    <= 1'b1;
                    state   <= S_RELEASE;
                end
                S_RELEASE: begin
                    hold_pin <= 1'b0;
                    state    <= S_DONE;
                end
                S_DONE: begin
                    if (sw_acc) begin
                        addr_q  <= acc[4:0];
                        wdata_q <= sw_wdata;
                        wr_q    <= acc[8];
                        rd_q    <= !acc[8];
                        state   <= S_ACC;
                    end else if (sw_start) begin
                        state <= S_IDLE;
                    end
                end
                S_ACC: state <= S_ACC_RD;
                S_ACC_RD: begin
                    rd_val <= link_rd;
                    state  <= S_DONE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cfg        <= 16'h0000;
            acc        <= 16'h0000;
            rd_pend    <= 1'b0;
            sw_rdata_q <= 16'h0000;
        end else begin
            if (sw_wr && sw_addr == HR_CONFIG) cfg <= sw_wdata;
            if (sw_wr && sw_addr == HR_CONTROL) acc <= {7'h00, sw_wdata[9:1]};
            rd_pend <= sw_rd;
            if (sw_rd) begin
                case (sw_addr)
                    HR_CONFIG: sw_rdata_q <= cfg;
                    HR_STATUS: sw_rdata_q <= {14'h0000, state == S_DONE, state != S_IDLE};
                    HR_RDATA:  sw_rdata_q <= rd_val;
                    default:   sw_rdata_q <= 16'h0000;
                endcase
            end
        end
    end

    assign sw_rdata               = sw_rdata_q;
    assign patch_req              = (state == S_PATCH);
    assign mgmt.hw_reset_b        = hw_rst_b;
    assign mgmt.hold_inactive_pin = hold_pin;
    assign mgmt.addr              = addr_q;
    assign mgmt.wdata             = wdata_q;
    assign mgmt.wr                = wr_q;
    assign mgmt.rd                = rd_q;
endmodule : pmc_host_ctrl

// >>> pmc_link_props.sv
// Checker on the management link between host controller and register bank.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/100ps
module pmc_link_props
    import pmc_pkg::*;
#(
    parameter int RST_WAIT = 50
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Link
    input wire logic        hw_reset_b,
    input wire logic        hold_inactive_pin,
    input wire logic [4:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    int          wait_cnt;
    int          gap_cnt;
    logic [15:0] page;
    wire         sw_rst_wr = wr && addr == REG_MODE_CONTROL && wdata[MC_SW_RESET];
    always_ff @(posedge clk_sys) begin
        gap_cnt <= sw_rst_wr ? 0 : gap_cnt + 1;
        if (!rst_b || !hw_reset_b)
            wait_cnt <= 0;
        else if (wait_cnt < RST_WAIT)
            wait_cnt <= wait_cnt + 1;
    end
    // Page as last written by the host
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !hw_reset_b || sw_rst_wr)
            page <= PAGE_MAIN;
        else if (wr && addr == REG_PAGE_SELECT)
            page <= wdata;
    end
    sequence s_swrst;
        sw_rst_wr;
    endsequence
    sequence s_poll;
        rd && addr == REG_MODE_CONTROL;
    endsequence
    chk_reset_quiet: assert property (!hw_reset_b |-> !wr && !rd)
        else $error("link access while device held in reset");
    chk_early_access: assert property ((wr || rd) |-> wait_cnt >= RST_WAIT - 1)
        else $error("link access before reset wait ended");
    chk_swrst_gap: assert property ((wr || rd) |-> gap_cnt >= SWRST_WAIT_CYC - 1)
        else $error("link access too soon after software reset");
    chk_swrst_poll: assert property (s_swrst |-> ##[10:60] s_poll)
        else $error("mode register not polled after software reset");
    chk_page_main: assert property (wr && addr == REG_EXT_PHY_CTL1 |-> page == PAGE_MAIN)
        else $error("interface mode register written off main page");
    chk_page_ext: assert property (wr && addr == REG_RGMII_DELAY |-> page == PAGE_EXT2)
        else $error("delay register written off page two");
    chk_delay_enable: assert property (wr && addr == REG_RGMII_DELAY |-> !wdata[RD_ENABLE_BIT])
        else $error("delay register written with bit 11 set");
    chk_reserved_zero: assert property (s_poll |=> rdata[5:0] == 6'h00)
        else $error("reserved mode bits read nonzero");
endmodule : pmc_link_props

// >>> pmc_mgmt_if.sv
// Management access link between host controller and register bank.
// Single-cycle access: read data is valid the cycle after the read strobe.
`timescale 1ns/100ps
interface pmc_mgmt_if (
    input wire logic clk_sys
);
    logic        hw_reset_b;
    logic        hold_inactive_pin;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;

    modport device (
        input  hw_reset_b, hold_inactive_pin, addr, wdata, wr, rd,
        output rdata
    );
    modport host (
        output hw_reset_b, hold_inactive_pin, addr, wdata, wr, rd,
        input  rdata
    );
endinterface : pmc_mgmt_if

// >>> pmc_pkg.sv
// Shared constants for the management register bank and its host controller.
// Assumes one 10 MHz system clock shared by both ends.
package pmc_pkg;
    // ----------------------------------------------------------------
    // Management register addresses and page values
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_MODE_CONTROL  = 5'h00;
    localparam logic [4:0] REG_MASTER_SLAVE  = 5'h09;
    localparam logic [4:0] REG_C45_CTRL      = 5'h0d;
    localparam logic [4:0] REG_C45_DATA      = 5'h0e;
    localparam logic [4:0] REG_EXT_PHY_CTL1  = 5'h17;
    localparam logic [4:0] REG_RGMII_DELAY   = 5'h14;
    localparam logic [4:0] REG_PAGE_SELECT   = 5'h1f;
    localparam logic [15:0] PAGE_MAIN        = 16'h0000;
    localparam logic [15:0] PAGE_EXT2        = 16'h0002;

    // ----------------------------------------------------------------
    // Mode control and other register fields
    // ----------------------------------------------------------------
    localparam int MC_SW_RESET    = 15;
    localparam int MC_LOOPBACK    = 14;
    localparam int MC_SPEED_LSB   = 13;
    localparam int MC_ISOLATE     = 10;
    localparam int MC_RESTART_AN  = 9;
    localparam int MC_DUPLEX      = 8;
    localparam int MC_COLL_TEST   = 7;
    localparam int MC_SPEED_MSB   = 6;
    localparam int EPC_MAC_RGMII  = 12;
    localparam int RD_ENABLE_BIT  = 11;
    localparam logic [15:0] MC_WMASK    = 16'hffc0;
    localparam logic [15:0] MC_RESET    = 16'h1040;
    localparam logic [15:0] EPC_WMASK   = 16'hffff;
    localparam logic [15:0] EPC_RESET   = 16'h0000;
    localparam logic [15:0] RD_RESET    = 16'h0000;
    localparam logic [15:0] MS_RESET    = 16'h0000;
    localparam logic [15:0] C45_RESET   = 16'h0000;
    localparam logic [2:0]  RD_DELAY_DEF = 3'h2;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int RST_WAIT_MS     = 120;
    localparam int RST_WAIT_CYC    = (RST_WAIT_MS * (CLK_HZ / 1000));
    localparam int SWRST_WAIT_US   = 1;
    localparam int SWRST_WAIT_CYC  = (SWRST_WAIT_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int SWRST_BUSY_CYC  = 4;
    localparam int AN_BUSY_CYC     = 4;

    // ----------------------------------------------------------------
    // Host register port
    // ----------------------------------------------------------------
    localparam logic [3:0] HR_CONTROL = 4'h0;
    localparam logic [3:0] HR_CONFIG  = 4'h1;
    localparam logic [3:0] HR_STATUS  = 4'h2;
    localparam logic [3:0] HR_ACC     = 4'h3;
    localparam logic [3:0] HR_RDATA   = 4'h4;

    typedef enum logic [1:0] {PMC_SPD_10, PMC_SPD_100, PMC_SPD_1000, PMC_SPD_RSVD} pmc_speed_e;
endpackage : pmc_pkg

// >>> pmc_pulse_timer.sv
// Down counter that holds a busy level for a fixed number of cycles.
// Assumes start is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
module pmc_pulse_timer
    import pmc_pkg::*;
#(
    parameter int CYCLES = 4
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Control
    input  wire logic start,
    output logic      busy
);
    logic [23:0] count;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count <= 24'h000000;
        end else if (start) begin
            count <= 24'(CYCLES);
        end else if (count != 24'h000000) begin
            count <= count - 24'h000001;
        end
    end

    assign busy = (count != 24'h000000);
endmodule : pmc_pulse_timer
